// *** lirm_consts.vh ***
/*
  Constants for the line input to ADC mixer routing register block.
  Assumes inclusion by bare name from any design file of the block.
*/
`ifndef LIRM_CONSTS_VH
`define LIRM_CONSTS_VH

// ************************************************************
// Register map (printed offsets are register indexes)
// ************************************************************
`define LIRM_IDX_RIGHT_TO_LEFT 8'h15
`define LIRM_IDX_RIGHT_TO_RIGHT 8'h16
`define LIRM_ADDR_W 10

// ************************************************************
// Field layout and reset values
// ************************************************************
`define LIRM_WIRING_BIT 7
`define LIRM_LEVEL_HI 6
`define LIRM_LEVEL_LO 3
`define LIRM_POWER_BIT 2
`define LIRM_STEP_HI 1
`define LIRM_STEP_LO 0
`define LIRM_LEVEL_MAX 4'h8
`define LIRM_LEVEL_OFF 4'hF
`define LIRM_RST_LEFT 8'h78
`define LIRM_RST_RIGHT 8'h78
`define LIRM_STEP_ONE 2'h0
`define LIRM_STEP_TWO 2'h1

// ************************************************************
// Gain register width and reset
// ************************************************************
`define LIRM_GAIN_W 7
`define LIRM_GAIN_RST 7'h00

`endif

// *** lirm_soft_step.v ***
/*
  Soft-stepping engine for the right ADC gain.
  Assumes a one-cycle sample-rate pulse synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lirm_consts.vh"

module lirm_soft_step #(
  parameter GAIN_W = `LIRM_GAIN_W
) (
  input wire core_clk,
  input wire arst_n,
  input wire sample_tick,
  input wire [1:0] step_mode,
  input wire [GAIN_W-1:0] gain_target,
  output reg [GAIN_W-1:0] gain_applied
);

  reg half;
  wire step_en;

  // In two-period mode only every second sample pulse moves the gain.
  assign step_en = sample_tick &&
    ((step_mode == `LIRM_STEP_ONE) ||
     (step_mode == `LIRM_STEP_TWO && half));

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      half <= 1'b0;
      gain_applied <= `LIRM_GAIN_RST;
    end else begin
      if (sample_tick) begin
        half <= ~half;
      end
      if (step_mode[1]) begin
        gain_applied <= gain_target;
      end else if (step_en && gain_applied < gain_target) begin
        gain_applied <= gain_applied + 1'b1;
      end else if (step_en && gain_applied > gain_target) begin
        gain_applied <= gain_applied - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** lirm_routing_regs.v ***
/*
  Routing registers for the right line input into the left and right ADC
  mixers, reached over Avalon-MM with waitrequest.
  Assumes a synchronous master and a one-cycle sample-rate pulse input.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lirm_consts.vh"

// Contract
// - Bit 7 of each routing register selects single-ended (0) or fully differential (1) wiring, reset 0.
// - Level bits 6 to 3 give 0 dB at code 0 and 1.5 dB more attenuation per code up to code 8.
// - Level code 15 disconnects the input from that mixer and is the reset value.
// - Any valid attenuation code connects the input to the mixer with no other control.
// - Bits 2 to 0 of the left-path register are read-only zero, and software writes zeros.
// - Bit 2 of the right-path register powers the right ADC channel, reset powered down.
// - Bits 1 to 0 of the right-path register step gain per sample, per two samples, or not at all.
module lirm_routing_regs #(
  parameter GAIN_W = `LIRM_GAIN_W
) (
  input wire core_clk,
  input wire arst_n,
  input wire [`LIRM_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  input wire sample_tick,
  input wire [GAIN_W-1:0] right_gain_target,
  output wire [GAIN_W-1:0] right_gain_applied,
  output wire left_mix_wiring_diff,
  output wire left_mix_connect,
  output wire [3:0] left_mix_atten,
  output wire right_mix_wiring_diff,
  output wire right_mix_connect,
  output wire [3:0] right_mix_atten,
  output wire right_adc_power_up
);

  // ************************************************************
  // Register storage
  // ************************************************************
  reg [7:0] line_in_right_to_left_adc_mix;
  reg [7:0] line_in_right_to_right_adc_mix;
  reg [7:0] next_left;
  reg [7:0] next_right;
  reg left_connect;
  reg right_connect;
  reg state;
  reg next_state;
  reg [31:0] next_readdata;
  reg [1:0] next_response;
  wire sel_left;
  wire sel_right;
  wire req;
  wire start;
  wire take;
  wire wr_accept;

  // ************************************************************
  // Bus answer states and response codes
  // ************************************************************
  // Response codes follow the usual Avalon meanings.
  localparam ST_IDLE = 1'b0;
  localparam ST_ANSWER = 1'b1;
  localparam RESP_OK = 2'h0;
  localparam RESP_SLVERR = 2'h2;

  // Level code is a usable attenuation when it is 0 to 8.
  function level_valid;
    input [3:0] code;
    begin
      level_valid = (code <= `LIRM_LEVEL_MAX);
    end
  endfunction

  // A register answers only at its own word; a byte offset inside the
  // word is refused rather than aliased.
  function index_hit;
    input [`LIRM_ADDR_W-1:0] addr;
    input [7:0] index;
    begin
      index_hit = (addr[1:0] == 2'h0) && (addr[9:2] == index);
    end
  endfunction

  // Level field of a routing register.
  function [3:0] level_of;
    input [7:0] value;
    begin
      level_of = value[`LIRM_LEVEL_HI:`LIRM_LEVEL_LO];
    end
  endfunction

  // Word address carries the register index.
  assign sel_left = index_hit(avs_address, `LIRM_IDX_RIGHT_TO_LEFT);
  assign sel_right = index_hit(avs_address, `LIRM_IDX_RIGHT_TO_RIGHT);
  assign req = avs_read || avs_write;
  assign start = req && (state == ST_IDLE);
  assign take = req && (state == ST_ANSWER);
  assign wr_accept = take && avs_write && avs_byteenable[0];

  // ************************************************************
  // Bus handshake
  // ************************************************************
  // Every access waits one cycle so read data comes from flip-flops.
  // The answer state lasts one cycle, so a master that keeps its request
  // up is simply taken again as a new access.
  assign avs_waitrequest = start;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req) begin
          next_state = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    next_readdata = 32'h0000_0000;
    next_response = RESP_OK;
    if (sel_left) begin
      next_readdata = {24'h00_0000, line_in_right_to_left_adc_mix};
    end else if (sel_right) begin
      next_readdata = {24'h00_0000, line_in_right_to_right_adc_mix};
    end else begin
      next_response = RESP_SLVERR;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      avs_readdata <= 32'h0000_0000;
      avs_response <= RESP_OK;
    end else begin
      state <= next_state;
      if (start) begin
        avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
        avs_response <= next_response;
      end
    end
  end

  // ************************************************************
  // Register write path
  // ************************************************************
  // A write lands only at the edge that ends the answer cycle, the same
  // edge at which the master sees waitrequest low.
  always @* begin
    next_left = line_in_right_to_left_adc_mix;
    next_right = line_in_right_to_right_adc_mix;
    if (wr_accept && sel_left) begin
      // Low three bits stay zero whatever is written.
      next_left = {avs_writedata[7:3], 3'h0};
    end
    if (wr_accept && sel_right) begin
      next_right = avs_writedata[7:0];
    end
  end

  // The connect flags are kept in flip-flops beside the fields they
  // decode, so the mixers never see a decode glitch.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_in_right_to_left_adc_mix <= `LIRM_RST_LEFT;
      line_in_right_to_right_adc_mix <= `LIRM_RST_RIGHT;
      // The reset level code disconnects both mixers.
      left_connect <= 1'b0;
      right_connect <= 1'b0;
    end else begin
      line_in_right_to_left_adc_mix <= next_left;
      line_in_right_to_right_adc_mix <= next_right;
      left_connect <= level_valid(level_of(next_left));
      right_connect <= level_valid(level_of(next_right));
    end
  end

  // ************************************************************
  // Mixer routing outputs
  // ************************************************************
  // Reserved codes 9 to 14 are treated as disconnected so a bad write
  // can never drive the mixer at an undefined level.
  assign left_mix_wiring_diff =
    line_in_right_to_left_adc_mix[`LIRM_WIRING_BIT];
  assign left_mix_atten = line_in_right_to_left_adc_mix[6:3];
  assign left_mix_connect = left_connect;
  assign right_mix_wiring_diff =
    line_in_right_to_right_adc_mix[`LIRM_WIRING_BIT];
  assign right_mix_atten = line_in_right_to_right_adc_mix[6:3];
  assign right_mix_connect = right_connect;
  assign right_adc_power_up =
    line_in_right_to_right_adc_mix[`LIRM_POWER_BIT];

  // ************************************************************
  // Right ADC gain soft-stepping
  // ************************************************************
  lirm_soft_step #(
    .GAIN_W(GAIN_W)
  ) u_step (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sample_tick(sample_tick),
    .step_mode(line_in_right_to_right_adc_mix[1:0]),
    .gain_target(right_gain_target),
    .gain_applied(right_gain_applied)
  );

endmodule
`default_nettype wire

// *** lirm_routing_regs_properties.sv ***
/*
  Checker for the routing register block.
  Assumes it is bound to lirm_routing_regs and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module lirm_props (
  input wire core_clk,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire left_mix_wiring_diff,
  input wire left_mix_connect,
  input wire [3:0] left_mix_atten,
  input wire right_mix_connect,
  input wire [3:0] right_mix_atten,
  input wire right_adc_power_up
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire req = avs_read | avs_write;
  sequence rd_s(a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait not one cycle");
  first_wait_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait on new request");
  left_conn_a: assert property (left_mix_connect == (left_mix_atten <= 4'h8))
    else $error("left connect wrong");
  right_conn_a: assert property (right_mix_connect == (right_mix_atten < 4'h9))
    else $error("right connect wrong");
  wiring_wr_a: assert property (avs_write && !avs_waitrequest &&
    avs_byteenable[0] && avs_address == 10'h054 |=>
    left_mix_wiring_diff == $past(avs_writedata[7]))
    else $error("left wiring not written");
  level_rd_a: assert property (rd_s(10'h054) |-> avs_readdata[7:0] ==
    {left_mix_wiring_diff, left_mix_atten, 3'h0})
    else $error("left readback wrong");
  power_rd_a: assert property (rd_s(10'h058) |->
    avs_readdata[6:2] == {right_mix_atten, right_adc_power_up})
    else $error("right readback wrong");
  unmap_rd_a: assert property (rd_s(10'h3FC) |-> avs_response == 2'h2)
    else $error("unmapped read not refused");
endmodule
bind lirm_routing_regs lirm_props i_props (.core_clk, .arst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .avs_response, .left_mix_wiring_diff, .left_mix_connect,
  .left_mix_atten, .right_mix_connect, .right_mix_atten, .right_adc_power_up);
`default_nettype wire

// *** lirm_routing_regs_bench.sv ***
/*
  Self-checking bench for the routing registers.
  Assumes the checker file is compiled alongside the design.
*/
`timescale 1ns/100ps
`default_nettype none
module lirm_routing_regs_bench;
  // ****************************************
  // Signals, design and clock
  // ****************************************
  logic core_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, sample_tick = 0;
  logic [9:0] avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hF, be = 4'hF;
  logic [6:0] right_gain_target = 0;
  logic [1:0] tc = 0;
  wire [31:0] avs_readdata;
  wire [1:0] avs_response;
  wire [6:0] right_gain_applied;
  wire [3:0] left_mix_atten, right_mix_atten;
  wire avs_waitrequest, left_mix_wiring_diff, left_mix_connect;
  wire right_mix_wiring_diff, right_mix_connect, right_adc_power_up;
  int fails = 0, n_checks = 0, nt = 0;
  logic [7:0] q, d;
  logic [9:0] a;
  lirm_routing_regs i_dut (.core_clk, .arst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .sample_tick, .right_gain_target,
    .right_gain_applied, .left_mix_wiring_diff, .left_mix_connect,
    .left_mix_atten, .right_mix_wiring_diff, .right_mix_connect,
    .right_mix_atten, .right_adc_power_up);
  initial forever #12.5 core_clk = ~core_clk;
  // Ticks every fourth cycle; nt counts the ticks the design has seen.
  always @(posedge core_clk) begin
    tc <= tc + 2'h1;
    sample_tick <= &tc;
    nt <= nt + sample_tick;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string n, input logic [7:0] x, input logic [7:0] y);
    n_checks++;
    if (x !== y) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, y);
    end
  endtask
  task bus(input logic w, input logic [9:0] ad, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0 && k++ < 50);
    q = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
    if (k > 50) begin
      fails++;
      $display("[FAIL] bus answer expected waitrequest low seen timeout");
      finish_test;
    end
  endtask
  // Expected readback: the left-path register keeps bits 2 to 0 at zero.
  function automatic logic [7:0] exp_rd(input logic rt, input logic [7:0] v);
    return rt ? v : {v[7:3], 3'h0};
  endfunction
  task step(input int m);
    int n1;
    logic [6:0] a1;
    @(posedge core_clk);
    a1 = right_gain_applied;
    n1 = nt;
    repeat (16) @(posedge core_clk);
    chk("gain step", 8'((nt - n1) / m), 8'(right_gain_applied - a1));
  endtask
  task finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(78406));
    repeat (12) @(posedge core_clk);
    arst_n <= 1;
    bus(0, 10'h054, 0);
    chk("left reset", 8'h78, q);
    bus(0, 10'h058, 0);
    chk("right reset", 8'h78, q);
    right_gain_target <= 7'h60;
    step(1);
    bus(1, 10'h058, 8'h05);
    step(2);
    for (int m = 6; m < 8; m++) begin
      bus(1, 10'h058, 8'(m));
      right_gain_target <= 7'($urandom);
      repeat (2) @(posedge core_clk);
      chk("gain follow", right_gain_target, right_gain_applied);
    end
    repeat (20) begin
      d[7] = 1'($urandom);
      for (int j = 0; j < 2; j++) begin
        a = j ? 10'h058 : 10'h054;
        d[6:0] = 7'($urandom);
        if (d[6:3] > 4'h8) d[6:3] = 4'hF;
        if (!j) d[2:0] = 3'h0;
        bus(1, a, d);
        bus(0, a, 0);
        chk("readback", exp_rd(a[3], d), q);
        chk("outputs", {d[7:3], d[6:3] <= 4'h8, a[3] & d[2], 1'b0}, a[3] ?
          {right_mix_wiring_diff, right_mix_atten, right_mix_connect,
          right_adc_power_up, 1'b0} : {left_mix_wiring_diff, left_mix_atten,
          left_mix_connect, 2'h0});
      end
    end
    bus(1, 10'h054, {d[7], 7'h00});
    be = 4'hE;
    bus(1, 10'h054, {d[7], 7'h78});
    be = 4'hF;
    bus(1, 10'h055, {d[7], 7'h78});
    chk("offset write resp", 8'h02, {6'h0, avs_response});
    bus(0, 10'h054, 0);
    chk("ignored writes", {d[7], 7'h00}, q);
    chk("level zero connect", 8'h01, {7'h0, left_mix_connect});
    bus(1, 10'h3FC, 8'hFF);
    chk("unmapped write resp", 8'h02, {6'h0, avs_response});
    bus(0, 10'h3FC, 0);
    chk("unmapped data", 8'h00, q);
    chk("unmapped resp", 8'h02, {6'h0, avs_response});
    arst_n <= 0;
    repeat (2) @(posedge core_clk);
    chk("reset gain", 8'h00, {1'b0, right_gain_applied});
    chk("reset outputs", 8'h0F, {right_adc_power_up, right_mix_connect,
      left_mix_connect, right_mix_wiring_diff, right_mix_atten});
    arst_n <= 1;
    bus(0, 10'h058, 0);
    chk("second reset", 8'h78, q);
    bus(0, 10'h054, 0);
    chk("second reset left", 8'h78, q);
    finish_test;
  end
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
